/* pmx_pkg.sv */
// Shared constants, types and reset values of the power-management event block
package pmx_pkg;

  // ****************************************************************
  // Register offsets from the power-management I/O base
  // ****************************************************************
  localparam logic [15:0] OFS_EVENT_STATUS  = 16'h0000;  // 16-bit, low half of dword 0
  localparam logic [15:0] OFS_EVENT_ENABLE  = 16'h0002;  // 16-bit, high half of dword 0
  localparam logic [15:0] OFS_SLEEP_CONTROL = 16'h0004;  // 32-bit, dword 1

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_TICK_WRAP      = 0;   // Status and enable
  localparam int BIT_FW_NOTIFY      = 5;   // Status and enable
  localparam int BIT_BUTTON         = 8;   // Status and enable
  localparam int BIT_ALARM          = 10;  // Status and enable
  localparam int BIT_ROUTE_SELECT   = 0;   // Control
  localparam int BIT_FW_RELEASE     = 2;   // Control, write only
  localparam int BIT_SLEEP_KIND_LO  = 10;  // Control, 12:10
  localparam int BIT_SLEEP_GO       = 13;  // Control, write only

  // ****************************************************************
  // Reset values and options
  // ****************************************************************
  localparam logic [15:0] EVENT_ENABLE_RESET  = 16'h0000;
  localparam logic [31:0] SLEEP_CONTROL_RESET = 32'h0000_0000;
  localparam logic [2:0]  SYNC_RESET          = 3'h1;  // {override, alarm, button_n}
  localparam logic        DOZE_WITH_HALT      = 1'b1;  // Stop-grant also drives doze
  localparam int          ALARM_WELL_W        = 5;     // {alarm_sts, kind[2:0], alarm_en}
  localparam int          RESUME_WELL_W       = 2;     // {button_sts, button_en}

  // ****************************************************************
  // Sleep kinds
  // ****************************************************************
  typedef enum logic [2:0] {
    KIND_ON      = 3'b000,
    KIND_HALT    = 3'b001,
    KIND_RSV2    = 3'b010,
    KIND_RSV3    = 3'b011,
    KIND_RSV4    = 3'b100,
    KIND_RAM     = 3'b101,
    KIND_DISK    = 3'b110,
    KIND_OFF     = 3'b111
  } pmx_kind_e;

  // ****************************************************************
  // I/O request carrier
  // ****************************************************************
  typedef struct packed {
    logic [15:0] addr;   // Byte address, dword aligned
    logic        wr;     // Write strobe, one cycle
    logic        rd;     // Read strobe, one cycle
    logic [3:0]  be;     // Byte enables
    logic [31:0] wdata;
  } pmx_io_req_s;

  // ****************************************************************
  // Core-well state
  // ****************************************************************
  typedef struct packed {
    logic [2:0]  sync1;      // First synchroniser stage
    logic [2:0]  sync2;      // Second synchroniser stage
    logic        alarm_d;    // Previous synchronised alarm
    logic        tick_d;     // Previous timer bit 22
    logic        tick_sts;
    logic        fw_sts;
    logic        route;
    pmx_kind_e   sleep_act;  // Sleep state being held
    logic        fw_event;
    logic        mgmt_n;
    logic        os_irq;
    logic        wake;
    logic        halt_n;
    logic        doze_n;
    logic        s3_n;
    logic        s4_n;
    logic        s5_n;
    logic [31:0] rdata;
  } pmx_core_s;

  localparam pmx_core_s CORE_RESET = '{
    sync1: SYNC_RESET, sync2: SYNC_RESET, alarm_d: 1'b0, tick_d: 1'b0,
    tick_sts: 1'b0, fw_sts: 1'b0, route: 1'b0, sleep_act: KIND_ON,
    fw_event: 1'b0, mgmt_n: 1'b1, os_irq: 1'b0, wake: 1'b0,
    halt_n: 1'b1, doze_n: 1'b1, s3_n: 1'b1, s4_n: 1'b1, s5_n: 1'b1,
    rdata: 32'h0000_0000};

endpackage

/* pmx_well_bank.sv */
// Register bank for one power well with its own reset
`timescale 1ns/1ps
`default_nettype none

module pmx_well_bank
#(
  parameter int W = 2
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         wipe,
  input  wire logic [W-1:0] load_mask,
  input  wire logic [W-1:0] load_val,
  input  wire logic [W-1:0] set_mask,
  input  wire logic [W-1:0] clr_mask,
  output logic      [W-1:0] q
);

  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_q;

  // ****************************************************************
  // Per-bit next value: load, then clear, then set wins over both
  // ****************************************************************
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_comb
    begin
      if (set_mask[i])
        nxt_q[i] = 1'b1;
      else if (wipe || clr_mask[i])
        nxt_q[i] = 1'b0;
      else if (load_mask[i])
        nxt_q[i] = load_val[i];
      else
        nxt_q[i] = q_ff[i];
    end
  end

  // Well register, cleared only by this well's reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q_ff <= '0;
    else
      q_ff <= nxt_q;
  end

  assign q = q_ff;

endmodule

`default_nettype wire

/* pmx_event_sleep.sv */
// Power-management event enable, status and sleep control block
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - 16-bit read/write event enable at base plus 02h, resets to zero.
// - Alarm enable bit 10 lets alarm status raise routed interrupt or wake.
// - Alarm enable survives all resets except alarm-well reset and button override.
// - Button enable bit 8 gates only the interrupt; status always sets.
// - A button press always counts as a wake source.
// - Firmware-notify enable bit 5 with its status raises the OS interrupt.
// - Tick-wrap enable bit 0 routes wrap status by route select, else nothing.
// - 32-bit sleep control at base plus 04h, resets to zero, mixed access.
// - Writing one to sleep-go bit 13 starts sleep of selected kind.
// - Sleep kind bits 12:10 cleared only by the alarm-well reset.
// - Kind 000 is on; 001 asserts processor halt and doze; 010 to 100 reserved.
// - Kind 101 asserts only the third-level sleep output.
// - Kind 110 asserts third- and fourth-level sleep outputs.
// - Kind 111 asserts third-, fourth- and fifth-level sleep outputs.
// - Firmware-release bit 2 reads zero; writing one signals firmware.
// - Route select bit 0 steers alarm, button, wrap, general events: 0 mgmt.
// - Alarm status sets on the clock alarm, cleared by writing one.
// - Button status sets while the button input is low, regardless of enables.
// - Tick-wrap status sets when timer bit 22 falls.
// - Firmware release from firmware sets notify status, raising OS interrupt.
module pmx_event_sleep
(
  input  wire logic               CLOCK,
  input  wire logic               RESETN,
  input  wire logic               RESUME_RESETN,
  input  wire logic               ALARM_WELL_RESET_N,
  input  wire logic [15:0]        PM_IO_BASE,
  input  wire pmx_pkg::pmx_io_req_s IO_REQ,
  output logic      [31:0]        IO_RDATA,
  input  wire logic               BUTTON_INPUT_N,
  input  wire logic               BUTTON_OVERRIDE,
  input  wire logic               ALARM_INTR,
  input  wire logic               TICK_BIT22,
  input  wire logic               GENERAL_EVENT_STATUS,
  input  wire logic               OS_NOTIFY_RELEASE,
  output logic                    FW_EVENT,
  output logic                    MGMT_IRQ_N,
  output logic                    OS_EVENT_IRQ,
  output logic                    WAKE_EVENT,
  output logic                    CPU_HALT_REQ_N,
  output logic                    CPU_DOZE_N,
  output logic                    SLEEP3_OUT_N,
  output logic                    SLEEP4_OUT_N,
  output logic                    SLEEP5_OUT_N
);

  pmx_pkg::pmx_core_s st_ff;
  pmx_pkg::pmx_core_s nxt_st;

  logic [pmx_pkg::ALARM_WELL_W-1:0]  alarm_q;
  logic [pmx_pkg::ALARM_WELL_W-1:0]  alarm_load_mask;
  logic [pmx_pkg::ALARM_WELL_W-1:0]  alarm_load_val;
  logic [pmx_pkg::ALARM_WELL_W-1:0]  alarm_set;
  logic [pmx_pkg::ALARM_WELL_W-1:0]  alarm_clr;
  logic [pmx_pkg::RESUME_WELL_W-1:0] resume_q;
  logic [pmx_pkg::RESUME_WELL_W-1:0] resume_load_mask;
  logic [pmx_pkg::RESUME_WELL_W-1:0] resume_load_val;
  logic [pmx_pkg::RESUME_WELL_W-1:0] resume_set;
  logic [pmx_pkg::RESUME_WELL_W-1:0] resume_clr;

  logic                 hit_evt;
  logic                 hit_ctl;
  logic                 wr_sts_lo;
  logic                 wr_sts_hi;
  logic                 wr_en_lo;
  logic                 wr_en_hi;
  logic                 wr_ctl_lo;
  logic                 wr_ctl_hi;
  logic [15:0]          w_sts;
  logic [15:0]          w_en;
  logic [15:0]          w_ctl;
  logic                 alarm_en;
  logic [2:0]           sleep_kind;
  logic                 alarm_sts;
  logic                 button_en;
  logic                 button_sts;
  logic                 routed;
  logic                 sleeping;
  logic                 wake_now;
  logic [15:0]          rd_sts;
  logic [15:0]          rd_en;
  logic [15:0]          rd_ctl;
  logic                 en_fw_ff;
  logic                 en_tick_ff;

  // ****************************************************************
  // Address decode and write lanes
  // ****************************************************************
  always_comb
  begin
    hit_evt = 1'b0;
    hit_ctl = 1'b0;
    if (IO_REQ.addr[15:2] == PM_IO_BASE[15:2] + pmx_pkg::OFS_EVENT_STATUS[15:2])
      hit_evt = 1'b1;
    else if (IO_REQ.addr[15:2] == PM_IO_BASE[15:2] + pmx_pkg::OFS_SLEEP_CONTROL[15:2])
      hit_ctl = 1'b1;
  end

  // Status in bytes 0-1, enable in bytes 2-3 of the first dword
  assign wr_sts_lo = IO_REQ.wr && hit_evt && IO_REQ.be[0];
  assign wr_sts_hi = IO_REQ.wr && hit_evt && IO_REQ.be[1];
  assign wr_en_lo  = IO_REQ.wr && hit_evt && IO_REQ.be[2];
  assign wr_en_hi  = IO_REQ.wr && hit_evt && IO_REQ.be[3];
  assign wr_ctl_lo = IO_REQ.wr && hit_ctl && IO_REQ.be[0];
  assign wr_ctl_hi = IO_REQ.wr && hit_ctl && IO_REQ.be[1];
  assign w_sts     = IO_REQ.wdata[15:0];
  assign w_en      = IO_REQ.wdata[31:16];
  assign w_ctl     = IO_REQ.wdata[15:0];

  // ****************************************************************
  // Alarm well: alarm enable, sleep kind, alarm status
  // ****************************************************************
  assign alarm_en   = alarm_q[0];
  assign sleep_kind = alarm_q[3:1];
  assign alarm_sts  = alarm_q[4];

  // Loads from software, set from the clock alarm edge, write-one clears
  always_comb
  begin
    alarm_load_mask = {1'b0, {3{wr_ctl_hi}}, wr_en_hi};
    alarm_load_val  = {1'b0, w_ctl[pmx_pkg::BIT_SLEEP_KIND_LO +: 3],
                       w_en[pmx_pkg::BIT_ALARM]};
    alarm_set       = {st_ff.sync2[1] && !st_ff.alarm_d, 4'h0};
    alarm_clr       = {wr_sts_hi && w_sts[pmx_pkg::BIT_ALARM], 3'h0,
                       st_ff.sync2[2]};
  end

  pmx_well_bank #(.W(pmx_pkg::ALARM_WELL_W)) u_alarm_well
  (
    .clk       (CLOCK),
    .rst_n     (ALARM_WELL_RESET_N),
    .wipe      (1'b0),
    .load_mask (alarm_load_mask),
    .load_val  (alarm_load_val),
    .set_mask  (alarm_set),
    .clr_mask  (alarm_clr),
    .q         (alarm_q)
  );

  // ****************************************************************
  // Resume well: button enable and button status
  // ****************************************************************
  assign button_en  = resume_q[0];
  assign button_sts = resume_q[1];

  // Button status sets while the pin is low whatever the enable holds
  always_comb
  begin
    resume_load_mask = {1'b0, wr_en_hi};
    resume_load_val  = {1'b0, w_en[pmx_pkg::BIT_BUTTON]};
    resume_set       = {!st_ff.sync2[0], 1'b0};
    resume_clr       = {wr_sts_hi && w_sts[pmx_pkg::BIT_BUTTON], 1'b0};
  end

  pmx_well_bank #(.W(pmx_pkg::RESUME_WELL_W)) u_resume_well
  (
    .clk       (CLOCK),
    .rst_n     (RESUME_RESETN),
    .wipe      (1'b0),
    .load_mask (resume_load_mask),
    .load_val  (resume_load_val),
    .set_mask  (resume_set),
    .clr_mask  (resume_clr),
    .q         (resume_q)
  );

  // ****************************************************************
  // Event routing and wake sources
  // ****************************************************************
  assign routed   = (alarm_en && alarm_sts)
                 || (button_en && button_sts)
                 || (en_tick_ff && st_ff.tick_sts)
                 || GENERAL_EVENT_STATUS;
  assign sleeping = (st_ff.sleep_act != pmx_pkg::KIND_ON);
  // Button press wakes regardless of its enable
  assign wake_now = sleeping && ((alarm_en && alarm_sts) || button_sts);

  // Read-back images; write-only bits read as zero
  assign rd_sts = {5'h00, alarm_sts, 1'b0, button_sts, 2'h0, st_ff.fw_sts, 4'h0,
                   st_ff.tick_sts};
  assign rd_en  = {5'h00, alarm_en, 1'b0, button_en, 2'h0, en_fw_ff, 4'h0, en_tick_ff};
  assign rd_ctl = {2'h0, 1'b0, sleep_kind, 7'h00, 1'b0, 1'b0, st_ff.route};

  // ****************************************************************
  // Core-well enable bits kept outside the state record
  // ****************************************************************
  // Firmware-notify and tick-wrap enables
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      en_fw_ff   <= pmx_pkg::EVENT_ENABLE_RESET[pmx_pkg::BIT_FW_NOTIFY];
      en_tick_ff <= pmx_pkg::EVENT_ENABLE_RESET[pmx_pkg::BIT_TICK_WRAP];
    end
    else if (wr_en_lo)
    begin
      en_fw_ff   <= w_en[pmx_pkg::BIT_FW_NOTIFY];
      en_tick_ff <= w_en[pmx_pkg::BIT_TICK_WRAP];
    end
  end

  // ****************************************************************
  // Core next-state logic
  // ****************************************************************
  always_comb
  begin
    logic       mgmt_lvl;
    logic       os_lvl;
    logic       tick_lvl;
    pmx_pkg::pmx_kind_e kind_v;
    mgmt_lvl = 1'b0;
    os_lvl   = 1'b0;
    tick_lvl = 1'b0;
    kind_v   = pmx_pkg::KIND_ON;
    nxt_st   = st_ff;

    // Pin synchronisers; stage one feeds stage two only
    nxt_st.sync1   = {BUTTON_OVERRIDE, ALARM_INTR, BUTTON_INPUT_N};
    nxt_st.sync2   = st_ff.sync1;
    nxt_st.alarm_d = st_ff.sync2[1];
    nxt_st.tick_d  = TICK_BIT22;

    // Sticky status, set wins over a write-one clear
    if (wr_sts_lo && w_sts[pmx_pkg::BIT_TICK_WRAP])
      nxt_st.tick_sts = 1'b0;
    if (st_ff.tick_d && !TICK_BIT22)
      nxt_st.tick_sts = 1'b1;
    if (wr_sts_lo && w_sts[pmx_pkg::BIT_FW_NOTIFY])
      nxt_st.fw_sts = 1'b0;
    if (OS_NOTIFY_RELEASE)
      nxt_st.fw_sts = 1'b1;

    // Route select and firmware release
    if (wr_ctl_lo)
      nxt_st.route = w_ctl[pmx_pkg::BIT_ROUTE_SELECT];
    nxt_st.fw_event = wr_ctl_lo && w_ctl[pmx_pkg::BIT_FW_RELEASE];

    // Sleep start and wake-up
    if (wake_now)
      nxt_st.sleep_act = pmx_pkg::KIND_ON;
    if (wr_ctl_hi && w_ctl[pmx_pkg::BIT_SLEEP_GO])
      nxt_st.sleep_act = pmx_pkg::pmx_kind_e'(w_ctl[pmx_pkg::BIT_SLEEP_KIND_LO +: 3]);
    kind_v = nxt_st.sleep_act;

    // Interrupt levels from enabled status
    tick_lvl = en_tick_ff && st_ff.tick_sts;
    mgmt_lvl = !st_ff.route && (routed || tick_lvl);
    os_lvl   = (st_ff.route && routed) || (en_fw_ff && st_ff.fw_sts);
    nxt_st.mgmt_n = !mgmt_lvl;
    nxt_st.os_irq = os_lvl;
    nxt_st.wake   = wake_now;

    // Sleep outputs by kind
    nxt_st.halt_n = 1'b1;
    nxt_st.doze_n = 1'b1;
    nxt_st.s3_n   = 1'b1;
    nxt_st.s4_n   = 1'b1;
    nxt_st.s5_n   = 1'b1;
    case (kind_v)
      pmx_pkg::KIND_HALT:
      begin
        nxt_st.halt_n = 1'b0;
        nxt_st.doze_n = !pmx_pkg::DOZE_WITH_HALT;
      end
      pmx_pkg::KIND_RAM:
        nxt_st.s3_n = 1'b0;
      pmx_pkg::KIND_DISK:
      begin
        nxt_st.s3_n = 1'b0;
        nxt_st.s4_n = 1'b0;
      end
      pmx_pkg::KIND_OFF:
      begin
        nxt_st.s3_n = 1'b0;
        nxt_st.s4_n = 1'b0;
        nxt_st.s5_n = 1'b0;
      end
      default:
        nxt_st.halt_n = 1'b1;                           // On and reserved kinds
    endcase

    // Registered read data; unmapped reads return zero
    if (IO_REQ.rd && hit_evt)
      nxt_st.rdata = {rd_en, rd_sts};
    else if (IO_REQ.rd && hit_ctl)
      nxt_st.rdata = {16'h0000, rd_ctl};
    else if (IO_REQ.rd)
      nxt_st.rdata = 32'h0000_0000;
  end

  // Core state register
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      st_ff <= pmx_pkg::CORE_RESET;
    else
      st_ff <= nxt_st;
  end

  // ****************************************************************
  // Outputs, all from flip-flops
  // ****************************************************************
  assign IO_RDATA       = st_ff.rdata;
  assign FW_EVENT       = st_ff.fw_event;
  assign MGMT_IRQ_N     = st_ff.mgmt_n;
  assign OS_EVENT_IRQ   = st_ff.os_irq;
  assign WAKE_EVENT     = st_ff.wake;
  assign CPU_HALT_REQ_N = st_ff.halt_n;
  assign CPU_DOZE_N     = st_ff.doze_n;
  assign SLEEP3_OUT_N   = st_ff.s3_n;
  assign SLEEP4_OUT_N   = st_ff.s4_n;
  assign SLEEP5_OUT_N   = st_ff.s5_n;

endmodule

`default_nettype wire

/* pmx_checker_props.sv */
// Concurrent checks on the ports of the power-management event block
`timescale 1ns/1ps
`default_nettype none

module pmx_checker_props
(
  input wire logic                 CLOCK,
  input wire logic                 RESETN,
  input wire logic [15:0]          PM_IO_BASE,
  input wire pmx_pkg::pmx_io_req_s IO_REQ,
  input wire logic [31:0]          IO_RDATA,
  input wire logic                 BUTTON_INPUT_N,
  input wire logic                 FW_EVENT,
  input wire logic                 WAKE_EVENT,
  input wire logic                 CPU_HALT_REQ_N,
  input wire logic                 CPU_DOZE_N,
  input wire logic                 SLEEP3_OUT_N,
  input wire logic                 SLEEP4_OUT_N,
  input wire logic                 SLEEP5_OUT_N
);
  // ****************************************************************
  // Address decode and properties
  // ****************************************************************
  logic hit0;
  logic hit1;
  logic go1;

  // Dword hits and sleep-go writes with the upper control byte enabled
  assign hit0 = IO_REQ.addr[15:2] == PM_IO_BASE[15:2];
  assign hit1 = IO_REQ.addr[15:2] == PM_IO_BASE[15:2] + 14'h1;
  assign go1  = IO_REQ.wr && hit1 && IO_REQ.be[1] && SLEEP3_OUT_N;

  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  AST_HALT_ALONE: assert property (!CPU_HALT_REQ_N |-> SLEEP3_OUT_N && SLEEP5_OUT_N)
    else $error("halt request together with a deep sleep output");
  AST_DOZE_TRACKS: assert property (CPU_DOZE_N == CPU_HALT_REQ_N)
    else $error("doze output differs from halt request");
  AST_S4_NEEDS_S3: assert property (!SLEEP4_OUT_N |-> !SLEEP3_OUT_N && CPU_HALT_REQ_N)
    else $error("fourth-level sleep without third-level");
  AST_S5_NEEDS_S4: assert property (!SLEEP5_OUT_N |-> !SLEEP4_OUT_N)
    else $error("fifth-level sleep without fourth-level");
  AST_GO_RAM: assert property (go1 && IO_REQ.wdata[13:10] == 4'hd |-> ##2 !SLEEP3_OUT_N && SLEEP4_OUT_N)
    else $error("suspend to RAM outputs wrong");
  AST_GO_OFF: assert property (go1 && IO_REQ.wdata[13:10] == 4'hf |-> ##2 !SLEEP5_OUT_N)
    else $error("soft off not entered");
  AST_FW_PULSE: assert property (IO_REQ.wr && hit1 && IO_REQ.be[0] && IO_REQ.wdata[2] |-> ##[1:2] FW_EVENT)
    else $error("firmware event missing");
  AST_FW_SHORT: assert property (FW_EVENT |=> !FW_EVENT)
    else $error("firmware event longer than one cycle");
  AST_WO_ZERO: assert property (IO_REQ.rd && hit1 |=> IO_RDATA[13] == 1'b0 && IO_RDATA[2] == 1'b0)
    else $error("write-only control bit read back nonzero");
  AST_UNMAPPED: assert property (IO_REQ.rd && !hit0 && !hit1 |=> IO_RDATA == 32'h0)
    else $error("unmapped read not zero");
  AST_WAKE_RELEASE: assert property (WAKE_EVENT |=> SLEEP3_OUT_N && CPU_HALT_REQ_N)
    else $error("sleep outputs held after wake");
  AST_BUTTON_WAKE: assert property ((!SLEEP3_OUT_N && !BUTTON_INPUT_N)[*2] |-> ##[0:6] WAKE_EVENT)
    else $error("button press did not wake");
endmodule

bind pmx_event_sleep pmx_checker_props u_pmx_checker_props (.CLOCK(CLOCK), .RESETN(RESETN),
  .PM_IO_BASE(PM_IO_BASE), .IO_REQ(IO_REQ), .IO_RDATA(IO_RDATA), .BUTTON_INPUT_N(BUTTON_INPUT_N),
  .FW_EVENT(FW_EVENT), .WAKE_EVENT(WAKE_EVENT), .CPU_HALT_REQ_N(CPU_HALT_REQ_N),
  .CPU_DOZE_N(CPU_DOZE_N), .SLEEP3_OUT_N(SLEEP3_OUT_N), .SLEEP4_OUT_N(SLEEP4_OUT_N),
  .SLEEP5_OUT_N(SLEEP5_OUT_N));
`default_nettype wire

/* pmx_platform_model.sv */
// Platform model: power button pin and clock alarm line
`timescale 1ns/1ps
`default_nettype none

module pmx_platform_model
(
  input  wire logic press,
  input  wire logic ring,
  output logic      button_n,
  output logic      alarm_intr
);
  // ****************************************************************
  // Pin levels
  // ****************************************************************
  // Button pin is pulled up, low only while pressed
  assign button_n   = !press;
  assign alarm_intr = ring;
endmodule
`default_nettype wire

/* test_pmx_event_sleep.sv */
// Self-checking testbench of the power-management event block
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin failures++; \
  $display("wrong value %s expected %h seen %h", n, e, a); end end

module test_pmx_event_sleep;
  // ****************************************************************
  // Signals, clock, instances
  // ****************************************************************
  logic                 clk, rstn, rrst, arst, press, ring, ovr, tick, gen, rls, btn_n, alm;
  logic [15:0]          base;
  pmx_pkg::pmx_io_req_s req;
  logic [31:0]          rdata;
  logic                 fw, mgmt_n, os, wake, halt_n, doze_n, s3, s4, s5;
  int                   failures, comparisons, cycles;
  logic [4:0]           tbl [8] = '{5'h1f, 5'h07, 5'h1f, 5'h1f, 5'h1f, 5'h1b, 5'h19, 5'h18};

  initial begin clk = 0; forever #2 clk = ~clk; end

  pmx_platform_model u_pmx_platform_model (.press(press), .ring(ring), .button_n(btn_n),
    .alarm_intr(alm));
  pmx_event_sleep u_pmx_event_sleep (.CLOCK(clk), .RESETN(rstn), .RESUME_RESETN(rrst),
    .ALARM_WELL_RESET_N(arst), .PM_IO_BASE(base), .IO_REQ(req), .IO_RDATA(rdata),
    .BUTTON_INPUT_N(btn_n), .BUTTON_OVERRIDE(ovr), .ALARM_INTR(alm), .TICK_BIT22(tick),
    .GENERAL_EVENT_STATUS(gen), .OS_NOTIFY_RELEASE(rls), .FW_EVENT(fw), .MGMT_IRQ_N(mgmt_n),
    .OS_EVENT_IRQ(os), .WAKE_EVENT(wake), .CPU_HALT_REQ_N(halt_n), .CPU_DOZE_N(doze_n),
    .SLEEP3_OUT_N(s3), .SLEEP4_OUT_N(s4), .SLEEP5_OUT_N(s5));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One request cycle; returns once the answer has settled
  task automatic io(input logic w, input logic [15:0] ofs, input logic [3:0] be,
                    input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: base + ofs, wr: w, rd: !w, be: be, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(input logic [15:0] ofs, input logic [31:0] e);
    io(1'b0, ofs, 4'hf, 32'h0);
    `CHK("io_rdata", e, rdata);
  endtask

  task automatic irq(input logic m, input logic o);
    wt(4);
    `CHK("mgmt_irq_n", m, mgmt_n);
    `CHK("os_event_irq", o, os);
  endtask

  task automatic final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      failures++;
      final_report;
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    {rstn, rrst, arst, press, ring, ovr, gen, rls} = '0;
    tick = 1'b1;
    base = 16'h0400;
    req = '0;
    repeat (3) @(posedge clk);
    {rstn, rrst, arst} <= 3'h7;
    rd(16'h0, 32'h0);
    rd(16'h4, 32'h0);
    io(1'b1, 16'h0, 4'hc, 32'hffff_0000);
    rd(16'h0, 32'h0521_0000);
    rd(16'h8, 32'h0);
    io(1'b1, 16'h4, 4'h3, 32'h5);
    `CHK("fw_event", 1'b1, fw);
    rd(16'h4, 32'h1);
    @(posedge clk) gen <= 1'b1;
    irq(1'b1, 1'b1);
    io(1'b1, 16'h4, 4'h3, 32'h0);
    irq(1'b0, 1'b0);
    @(posedge clk) gen <= 1'b0;
    // Tick wrap through both routes
    for (int r = 0; r < 2; r++)
    begin
      io(1'b1, 16'h4, 4'h3, 32'(r));
      @(posedge clk) tick <= 1'b0;
      irq(r[0], r[0]);
      io(1'b1, 16'h0, 4'h3, 32'h1);
      irq(1'b1, 1'b0);
      @(posedge clk) tick <= 1'b1;
    end
    io(1'b1, 16'h4, 4'h3, 32'h0);
    @(posedge clk) rls <= 1'b1;
    @(posedge clk) rls <= 1'b0;
    irq(1'b1, 1'b1);
    rd(16'h0, 32'h0521_0020);
    io(1'b1, 16'h0, 4'h3, 32'h20);
    @(posedge clk) ring <= 1'b1;
    @(posedge clk) ring <= 1'b0;
    irq(1'b0, 1'b0);
    rd(16'h0, 32'h0521_0400);
    io(1'b1, 16'h0, 4'h3, 32'h400);
    // Sources with their enables off
    io(1'b1, 16'h0, 4'hc, 32'h0020_0000);
    io(1'b1, 16'h4, 4'h3, 32'h1);
    @(posedge clk) ring <= 1'b1;
    @(posedge clk) {ring, tick} <= 2'b00;
    @(posedge clk) {press, tick} <= 2'b11;
    irq(1'b1, 1'b0);
    rd(16'h0, 32'h0020_0501);
    @(posedge clk) press <= 1'b0;
    wt(4);
    io(1'b1, 16'h0, 4'h3, 32'h501);
    // Every sleep kind, then a button wake
    for (int k = 0; k < 8; k++)
    begin
      io(1'b1, 16'h4, 4'h3, {18'h0, 1'b1, 3'(k), 10'h0});
      wt(2);
      `CHK("sleep_pins", tbl[k], {halt_n, doze_n, s3, s4, s5});
      @(posedge clk) press <= 1'b1;
      wt(8);
      @(posedge clk) press <= 1'b0;
      wt(4);
      `CHK("woken_pins", 5'h1f, {halt_n, doze_n, s3, s4, s5});
      io(1'b1, 16'h0, 4'h3, 32'h100);
    end
    // Retention across the core reset, then the alarm-well clears
    io(1'b1, 16'h0, 4'hc, 32'h0400_0000);
    io(1'b1, 16'h4, 4'h3, 32'h1800);
    @(posedge clk) rstn <= 1'b0;
    @(posedge clk) rstn <= 1'b1;
    rd(16'h0, 32'h0400_0000);
    rd(16'h4, 32'h1800);
    @(posedge clk) ovr <= 1'b1;
    wt(4);
    @(posedge clk) ovr <= 1'b0;
    rd(16'h0, 32'h0);
    @(posedge clk) arst <= 1'b0;
    @(posedge clk) arst <= 1'b1;
    rd(16'h4, 32'h0);
    final_report;
  end
endmodule
`default_nettype wire
